// [wdcs_consts.svh]
// Offsets, field positions and timing counts of the watchdog sequencer
`ifndef WDCS_CONSTS_SVH
`define WDCS_CONSTS_SVH

`define WDCS_ADR_CONTROL    8'h00
`define WDCS_ADR_RESTART    8'h04
`define WDCS_ADR_STATUS     8'h08

`define WDCS_PRESCALE_MSB   2
`define WDCS_PRESCALE_LSB   0
`define WDCS_ON_BIT         3
`define WDCS_UNLOCK_BIT     4

`define WDCS_RESTART_BIT    0

`define WDCS_ST_LEVEL_LSB   0
`define WDCS_ST_LEVEL_MSB   1
`define WDCS_ST_WINDOW_BIT  2
`define WDCS_ST_RUN_BIT     3

`define WDCS_PRESCALE_RST   3'h0
`define WDCS_BASE_CYCLES    16384
`define WDCS_WINDOW_CYCLES  3'h4

`endif

// [wdcs_pkg.sv]
// Types shared by the watchdog configuration sequencer
package wdcs_pkg;

   typedef enum logic [1:0] {
      WDCS_LEVEL_0,
      WDCS_LEVEL_1,
      WDCS_LEVEL_2
   } wdcs_level_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wdcs_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wdcs_wb_rsp_t;

endpackage

// [wdcs_timeout.sv]
// Time-out counter on the system clock, advanced by watchdog oscillator ticks
`timescale 1ns/100ps
`include "wdcs_consts.svh"
module wdcs_timeout #(
   parameter int BASE_CYCLES = `WDCS_BASE_CYCLES,
   parameter int CNT_W       = 22
) (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       osc_tick,
   input  wire logic       run,
   input  wire logic       clear,
   input  wire logic [2:0] prescale,
   output logic            expire
);

   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] limit;

   // Each code step doubles the count
   assign limit = CNT_W'(BASE_CYCLES) << prescale;

   always_ff @(posedge clk) begin
      if (srst || !run || clear) begin
         count_reg <= '0;
      end else if (osc_tick) begin
         if (count_reg >= limit - CNT_W'(1)) begin
            count_reg <= '0;
         end else begin
            count_reg <= count_reg + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst || !run || clear) begin
         expire <= 1'b0;
      end else begin
         // Single-cycle pulse on the tick that reaches the limit
         expire <= osc_tick && (count_reg >= limit - CNT_W'(1));
      end
   end

endmodule

// [wdcs_top.sv]
// Watchdog configuration sequencer with Wishbone control registers
`timescale 1ns/100ps
`include "wdcs_consts.svh"

// Notes on behaviour
// - Three-bit prescale selects 16,384 to 2,097,152 oscillator cycles.
// - Level 0: prescale changes with a plain write.
// - Level 0: starts disabled; writing one to enable starts it.
// - Level 0: disabling needs the unlock write first.
// - Level 1: starts disabled; enabling needs no unlock.
// - Level 1: prescale change or disable only inside the window.
// - Level 1: second write within four cycles applies enable and prescale.
// - Level 2: watchdog always runs, enable reads one.
// - Level 2: second write sets prescale; enable value ignored.
// - Unlock bit clears by itself four cycles after set.
// - Safety level comes from compatibility and force-on fuses.
// - Expiry gives a one-cycle system reset pulse.
// - Counter clears on restart, disable and chip reset.
module wdcs_top
   import wdcs_pkg::*;
#(
   parameter int BASE_CYCLES = `WDCS_BASE_CYCLES,
   parameter int CNT_W       = 22
) (
   input  wire logic          clk,
   input  wire logic          srst,
   input  wire wdcs_wb_req_t  wb_req,
   output wdcs_wb_rsp_t       wb_rsp,
   input  wire logic          osc_tick,
   input  wire logic          legacy_compat_fuse,
   input  wire logic          force_on_fuse,
   output logic               wdt_reset,
   output logic               wdt_running
);

   wdcs_level_t level_reg;
   logic        on_reg;
   logic [2:0]  prescale_reg;
   logic [2:0]  window_reg;
   logic        restart_reg;
   logic        expire;

   logic        wr_req;
   logic        wr_ctrl;
   logic        wr_byte0;
   logic [7:0]  wr_data;
   logic        wr_on;
   logic        wr_unlock;
   logic [2:0]  wr_prescale;
   logic        window_open;
   logic        unlock_write;
   logic        on_next;
   logic [2:0]  prescale_next;
   logic [7:0]  ctrl_view;
   logic [7:0]  status_view;
   logic [31:0] rd_data;

   // Access is taken on the edge where the ack is raised
   assign wr_req   = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
   assign wr_byte0 = wr_req && wb_req.we && wb_req.sel[0];
   assign wr_ctrl  = wr_byte0 && (wb_req.adr == `WDCS_ADR_CONTROL);
   assign wr_data  = wb_req.dat[7:0];

   assign wr_on       = wr_data[`WDCS_ON_BIT];
   assign wr_unlock   = wr_data[`WDCS_UNLOCK_BIT];
   assign wr_prescale = wr_data[`WDCS_PRESCALE_MSB:`WDCS_PRESCALE_LSB];

   assign window_open  = (window_reg != 3'h0);
   assign unlock_write = wr_ctrl && wr_unlock && wr_on;

   // Fuses are sampled while reset is held
   always_ff @(posedge clk) begin
      if (srst) begin
         if (force_on_fuse) begin
            level_reg <= WDCS_LEVEL_2;
         end else if (legacy_compat_fuse) begin
            level_reg <= WDCS_LEVEL_0;
         end else begin
            level_reg <= WDCS_LEVEL_1;
         end
      end
   end

   // Unlock window: any control write closes it, the opener restarts it
   always_ff @(posedge clk) begin
      if (srst) begin
         window_reg <= 3'h0;
      end else if (unlock_write) begin
         window_reg <= `WDCS_WINDOW_CYCLES;
      end else if (wr_ctrl) begin
         window_reg <= 3'h0;
      end else if (window_open) begin
         window_reg <= window_reg - 3'h1;
      end
   end

   always_comb begin
      on_next       = on_reg;
      prescale_next = prescale_reg;
      if (wr_ctrl) begin
         case (level_reg)
            WDCS_LEVEL_0: begin
               prescale_next = wr_prescale;
               if (wr_on) begin
                  on_next = 1'b1;
               end else if (window_open && !wr_unlock) begin
                  on_next = 1'b0;
               end
            end
            WDCS_LEVEL_1: begin
               if (window_open && !wr_unlock) begin
                  on_next       = wr_on;
                  prescale_next = wr_prescale;
               end else if (wr_on) begin
                  on_next = 1'b1;
               end
               // Late second write keeps prescale; only a set enable bit takes effect
            end
            WDCS_LEVEL_2: begin
               if (window_open && !wr_unlock) begin
                  prescale_next = wr_prescale;
               end
            end
            default: begin
               on_next       = on_reg;
               prescale_next = prescale_reg;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         // Initial state follows the force-on fuse directly, level not yet latched
         on_reg <= force_on_fuse ? 1'b1 : 1'b0;
      end else if (level_reg == WDCS_LEVEL_2) begin
         on_reg <= 1'b1;
      end else begin
         on_reg <= on_next;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         prescale_reg <= `WDCS_PRESCALE_RST;
      end else begin
         prescale_reg <= prescale_next;
      end
   end

   // Restart command stands in for the restart instruction
   always_ff @(posedge clk) begin
      if (srst) begin
         restart_reg <= 1'b0;
      end else begin
         restart_reg <= wr_byte0 && (wb_req.adr == `WDCS_ADR_RESTART)
                        && wb_req.dat[`WDCS_RESTART_BIT];
      end
   end

   wdcs_timeout #(
      .BASE_CYCLES (BASE_CYCLES),
      .CNT_W       (CNT_W)
   ) u_timeout (
      .clk      (clk),
      .srst     (srst),
      .osc_tick (osc_tick),
      .run      (on_reg),
      .clear    (restart_reg),
      .prescale (prescale_reg),
      .expire   (expire)
   );

   always_ff @(posedge clk) begin
      if (srst) begin
         wdt_reset <= 1'b0;
      end else begin
         wdt_reset <= expire;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wdt_running <= 1'b0;
      end else begin
         wdt_running <= on_reg;
      end
   end

   // Reserved bits 7..5 read zero; unlock bit reads the open window
   always_comb begin
      ctrl_view = 8'h00;
      ctrl_view[`WDCS_PRESCALE_MSB:`WDCS_PRESCALE_LSB] = prescale_reg;
      ctrl_view[`WDCS_ON_BIT]     = on_reg;
      ctrl_view[`WDCS_UNLOCK_BIT] = window_open;
   end

   always_comb begin
      status_view = 8'h00;
      status_view[`WDCS_ST_LEVEL_MSB:`WDCS_ST_LEVEL_LSB] = level_reg;
      status_view[`WDCS_ST_WINDOW_BIT] = window_open;
      status_view[`WDCS_ST_RUN_BIT]    = on_reg;
   end

   always_comb begin
      case (wb_req.adr)
         `WDCS_ADR_CONTROL: rd_data = {24'h00_0000, ctrl_view};
         `WDCS_ADR_STATUS:  rd_data = {24'h00_0000, status_view};
         default:           rd_data = 32'h0000_0000;
      endcase
   end

   // Every address answers in one cycle; unmapped reads return zero
   always_ff @(posedge clk) begin
      if (srst) begin
         wb_rsp.ack <= 1'b0;
         wb_rsp.dat <= 32'h0000_0000;
      end else begin
         wb_rsp.ack <= wr_req;
         wb_rsp.dat <= (wr_req && !wb_req.we) ? rd_data : 32'h0000_0000;
      end
   end

endmodule

// [wdcs_top_chk.sv]
// Port assertions of the watchdog sequencer
`timescale 1ns/100ps
module wdcs_top_chk
   import wdcs_pkg::*;
#(
   parameter int BASE_CYCLES = 16,
   parameter int CNT_W       = 22
) (
   input wire logic         clk,
   input wire logic         srst,
   input wire wdcs_wb_req_t wb_req,
   input wire wdcs_wb_rsp_t wb_rsp,
   input wire logic         osc_tick,
   input wire logic         legacy_compat_fuse,
   input wire logic         force_on_fuse,
   input wire logic         wdt_reset,
   input wire logic         wdt_running
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_take;
      wb_req.cyc && wb_req.stb && !wb_rsp.ack;
   endsequence
   sequence s_pulse;
      wb_rsp.ack ##1 !wb_rsp.ack;
   endsequence
   property p_ack;
      s_take |=> s_pulse;
   endproperty
   property p_idle_dat;
      !wb_rsp.ack |-> wb_rsp.dat == 32'h0000_0000;
   endproperty
   property p_hi_zero;
      wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h00_0000;
   endproperty
   property p_rst_pulse;
      wdt_reset |=> !wdt_reset;
   endproperty
   // Expiry is only ever counted on an oscillator tick
   property p_rst_cause;
      wdt_reset |-> $past(osc_tick, 2);
   endproperty
   property p_forced;
      force_on_fuse && !$past(srst) |-> wdt_running;
   endproperty
   property p_no_drop;
      force_on_fuse |-> !$fell(wdt_running);
   endproperty
   property p_low_start;
      !force_on_fuse && $past(srst) |-> !wdt_running;
   endproperty
   a_ack:
      assert property (p_ack) else $error("ack timing wrong");
   a_idle_dat:
      assert property (p_idle_dat) else $error("data without ack");
   a_hi_zero:
      assert property (p_hi_zero) else $error("upper data not zero");
   a_rst_pulse:
      assert property (p_rst_pulse) else $error("reset pulse too long");
   a_rst_cause:
      assert property (p_rst_cause) else $error("reset without tick");
   a_forced:
      assert property (p_forced) else $error("forced level not running");
   a_no_drop:
      assert property (p_no_drop) else $error("forced watchdog stopped");
   a_low_start:
      assert property (p_low_start) else $error("started enabled");
endmodule

// [wdcs_top_test.sv]
// Self-checking bench of the watchdog sequencer
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
   $display("Error t=%0t got %h exp %h", $time, g, e); end end
module wdcs_top_test
   import wdcs_pkg::*;
();
   logic         clk = 1'b0;
   logic         srst = 1'b1;
   logic         osc_tick = 1'b0;
   logic         legacy_compat_fuse = 1'b1;
   logic         force_on_fuse = 1'b0;
   logic         wdt_reset;
   logic         wdt_running;
   wdcs_wb_req_t wb_req = '0;
   wdcs_wb_rsp_t wb_rsp;
   logic [31:0]  exp_q[$];
   logic [31:0]  e_v;
   logic [15:0]  seed = 16'ha10e;
   int           fails = 0;
   int           n_compared = 0;
   int           n_wdr = 0;
   int           n0;
   always #10 clk = ~clk;
   always @(posedge clk) osc_tick <= ~osc_tick;
   always @(posedge clk) if (wdt_reset === 1'b1) n_wdr++;
   always @(posedge clk) if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0) begin
      e_v = exp_q.pop_front();
      `CHK(wb_rsp.dat, e_v)
   end
   // Short base count keeps time-outs within a few hundred clocks
   wdcs_top #(.BASE_CYCLES(16), .CNT_W(22)) wdcs_top_i (.clk(clk),
      .srst(srst), .wb_req(wb_req), .wb_rsp(wb_rsp), .osc_tick(osc_tick),
      .legacy_compat_fuse(legacy_compat_fuse), .force_on_fuse(force_on_fuse),
      .wdt_reset(wdt_reset), .wdt_running(wdt_running));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wb_req <= '{1'b1, 1'b1, w, a, 4'hf, {24'h00_0000, d}};
      do @(posedge clk); while (wb_rsp.ack !== 1'b1);
      wb_req.cyc <= 1'b0;
      wb_req.stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back({24'h00_0000, e});
      bus(1'b0, a, 8'h00);
   endtask
   // Fuses move only while reset is held
   task automatic boot(input logic c, input logic f);
      srst <= 1'b1;
      legacy_compat_fuse <= c;
      force_on_fuse <= f;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
   endtask
   task automatic wrap_up;
      $display("fails=%0d n_compared=%0d", fails, n_compared);
      if (fails == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      wrap_up();
   end
   initial begin
      boot(1'b1, 1'b0);
      rd(8'h00, 8'h00);
      rd(8'h08, 8'h00);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         wr(8'h40, seed[7:0]);
         wr(8'h00, i[7:0]);
         rd(8'h00, i[7:0]);
      end
      rd(8'h40, 8'h00);
      wr(8'h00, 8'h0d);
      rd(8'h00, 8'h0d);
      wr(8'h00, 8'h00);
      rd(8'h00, 8'h08);
      wr(8'h00, 8'h18);
      wr(8'h00, 8'h00);
      rd(8'h00, 8'h00);
      boot(1'b0, 1'b0);
      rd(8'h08, 8'h01);
      wr(8'h00, 8'h0d);
      rd(8'h00, 8'h08);
      wr(8'h00, 8'h00);
      rd(8'h00, 8'h08);
      wr(8'h00, 8'h18);
      wr(8'h00, 8'h03);
      rd(8'h00, 8'h03);
      wr(8'h00, 8'h18);
      rd(8'h08, 8'h0d);
      repeat (6) @(posedge clk);
      rd(8'h08, 8'h09);
      wr(8'h00, 8'h00);
      rd(8'h00, 8'h0b);
      boot(1'b0, 1'b1);
      rd(8'h00, 8'h08);
      rd(8'h08, 8'h0a);
      wr(8'h00, 8'h00);
      rd(8'h00, 8'h08);
      wr(8'h00, 8'h18);
      wr(8'h00, 8'h02);
      rd(8'h00, 8'h0a);
      wr(8'h04, 8'h01);
      n0 = n_wdr;
      repeat (10) begin
         wr(8'h04, 8'h01);
         repeat (10) @(posedge clk);
      end
      `CHK(n_wdr, n0)
      repeat (150) @(posedge clk);
      `CHK(n_wdr, n0 + 1)
      wrap_up();
   end
endmodule
bind wdcs_top wdcs_top_chk #(.BASE_CYCLES(BASE_CYCLES), .CNT_W(CNT_W)) chk_i (
   .clk(clk), .srst(srst), .wb_req(wb_req), .wb_rsp(wb_rsp),
   .osc_tick(osc_tick), .legacy_compat_fuse(legacy_compat_fuse),
   .force_on_fuse(force_on_fuse), .wdt_reset(wdt_reset),
   .wdt_running(wdt_running));
